/* File: hw/dpsc_core.sv */
`timescale 1ns/1ps

`include "dpsc_defs.svh"

// Operation
// - Store-user-word writes 16 data bits to addressed slot; 2 first, 3 second.
// - Spare store has 14 addressable slots of 16 bits each.
// - While a frame shifts in, the previous complete frame shifts out.
// - Read-memory only prepares the slot; contents leave in the next transfer.
// - Next output word is the read command byte plus 16 slot bits.
// - Host sends no-operation after readback; device returns to idle power.
// - Write-wiper loads low data bits into 10-bit wiper at once.
// - Left-shift doubles the wiper; midscale goes to full scale 0x3FF.
// - Read-wiper prepares wiper; next transfer sends command byte plus wiper.
// - Spare slots are nonvolatile 16-bit words, written by 3, read by 9.

// Top of the serial command interpreter
module dpsc_core
    import dpsc_pkg::*;
(
    // System clock and reset
    input  wire logic                    clock_i,
    input  wire logic                    rst_b_i,
    // Serial link pins
    input  wire logic                    serial_clk_i,
    input  wire logic                    cs_b_i,
    input  wire logic                    serial_data_in_i,
    output logic                         serial_data_out_o,
    // Device state
    output logic [`DPSC_WIPER_W-1:0]     wiper_register_o,
    output logic                         read_power_o,
    output logic                         frame_done_o,
    output logic                         frame_reject_o
);

    // ------------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------------
    logic [`DPSC_FRAME_W-1:0] link_frame;
    logic [`DPSC_CNT_W-1:0]   link_count;
    logic [`DPSC_FRAME_W-1:0] resp_q;
    logic [`DPSC_FRAME_W-1:0] resp_d;
    logic                     cs_s1_q;
    logic                     cs_s2_q;
    logic                     cs_s3_q;
    logic                     cs_release;
    logic                     len_ok;
    logic                     exec;
    dpsc_frame_s              frame;
    dpsc_wiper_t              wiper_q;
    dpsc_wiper_t              wiper_d;
    dpsc_wiper_t              wiper_dbl;
    dpsc_pwr_e                pwr_q;
    dpsc_pwr_e                pwr_d;
    logic [15:0]              store_mem [`DPSC_SLOT_DEPTH];
    logic [15:0]              slot_word;
    logic                     slot_valid;
    logic                     is_nop;
    logic                     is_store;
    logic                     is_read_mem;
    logic                     is_read_wiper;
    logic                     is_write_wiper;
    logic                     is_shift_left;
    logic                     store_we;

    // ------------------------------------------------------------------------
    // Link domain
    // ------------------------------------------------------------------------
    // Shifters on the host's serial clock
    dpsc_link u_link (
        .link_clk_i        (serial_clk_i),
        .rst_b_i           (rst_b_i),
        .cs_b_i            (cs_b_i),
        .serial_data_in_i  (serial_data_in_i),
        .serial_data_out_o (serial_data_out_o),
        .resp_i            (resp_q),
        .frame_o           (link_frame),
        .count_o           (link_count)
    );

    // ------------------------------------------------------------------------
    // Chip select crossing
    // ------------------------------------------------------------------------
    // Two-flop synchroniser plus one stage for edge detection
    always_ff @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            cs_s1_q <= 1'b1;
            cs_s2_q <= 1'b1;
            cs_s3_q <= 1'b1;
        end else begin
            cs_s1_q <= cs_b_i;
            cs_s2_q <= cs_s1_q;
            cs_s3_q <= cs_s2_q;
        end
    end

    // Release of chip select ends a frame; the link words are then static
    assign cs_release = cs_s2_q & ~cs_s3_q;
    assign len_ok     = (link_count == `DPSC_FRAME_BITS);
    assign exec       = cs_release & len_ok;

    // ------------------------------------------------------------------------
    // Instruction decode
    // ------------------------------------------------------------------------
    // Field split of the received frame
    assign frame          = dpsc_frame_s'(link_frame);
    assign is_nop         = (frame.opcode == `DPSC_OP_NOP);
    assign is_store       = (frame.opcode == `DPSC_OP_STORE_USER);
    assign is_read_mem    = (frame.opcode == `DPSC_OP_READ_MEM);
    assign is_read_wiper  = (frame.opcode == `DPSC_OP_READ_WIPER);
    assign is_write_wiper = (frame.opcode == `DPSC_OP_WRITE_WIPER);
    assign is_shift_left  = (frame.opcode == `DPSC_OP_SHIFT_LEFT);

    // Slots 2 to 15 form the 14 spare locations
    assign slot_valid = (frame.addr >= `DPSC_SLOT_FIRST);

    // ------------------------------------------------------------------------
    // Spare nonvolatile store
    // ------------------------------------------------------------------------
    // Write strobe for a store-user-word frame to a spare slot
    assign store_we  = exec & is_store & slot_valid;
    // Unmapped slots read back as zero
    assign slot_word = slot_valid ? store_mem[frame.addr] : `DPSC_WORD_ZERO;

    // Store array holds its contents through reset, as nonvolatile cells do
    always_ff @(posedge clock_i) begin
        if (store_we) begin
            store_mem[frame.addr] <= frame.data;
        end
    end

    // ------------------------------------------------------------------------
    // Wiper register
    // ------------------------------------------------------------------------
    // Doubling saturates at full scale so midscale lands on 0x3FF
    assign wiper_dbl = wiper_q[`DPSC_WIPER_W-1] ? `DPSC_WIPER_FULL :
                       {wiper_q[`DPSC_WIPER_W-2:0], 1'b0};

    // Next wiper value from write or shift frames
    always_comb begin
        wiper_d = wiper_q;
        if (exec && is_write_wiper) begin
            wiper_d = frame.data[`DPSC_WIPER_W-1:0];
        end else if (exec && is_shift_left) begin
            wiper_d = wiper_dbl;
        end
    end

    // Wiper powers up at midscale
    always_ff @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            wiper_q <= `DPSC_WIPER_MID;
        end else begin
            wiper_q <= wiper_d;
        end
    end

    // ------------------------------------------------------------------------
    // Reply word for the next transfer
    // ------------------------------------------------------------------------
    // Echo by default; read commands substitute their data into the low bits
    always_comb begin
        resp_d = resp_q;
        if (exec) begin
            if (is_read_mem) begin
                resp_d = {frame.opcode, frame.addr, slot_word};
            end else if (is_read_wiper) begin
                resp_d = {frame.opcode, frame.addr, `DPSC_WIPER_PAD, wiper_q};
            end else begin
                resp_d = link_frame;
            end
        end
    end

    // Reply register read by the link at the next frame's first edge
    always_ff @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            resp_q <= `DPSC_FRAME_ZERO;
        end else begin
            resp_q <= resp_d;
        end
    end

    // ------------------------------------------------------------------------
    // Power state
    // ------------------------------------------------------------------------
    // Read commands raise the read power state; a no-operation drops it
    always_comb begin
        pwr_d = pwr_q;
        case (pwr_q)
            DPSC_PWR_IDLE: begin
                if (exec && (is_read_mem || is_read_wiper)) begin
                    pwr_d = DPSC_PWR_READ;
                end
            end
            DPSC_PWR_READ: begin
                if (exec && is_nop) begin
                    pwr_d = DPSC_PWR_IDLE;
                end
            end
            default: begin
                pwr_d = DPSC_PWR_IDLE;
            end
        endcase
    end

    // Power state register
    always_ff @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            pwr_q <= DPSC_PWR_IDLE;
        end else begin
            pwr_q <= pwr_d;
        end
    end

    // ------------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------------
    // Registered copies of the device state and one-cycle frame strobes
    always_ff @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            wiper_register_o <= `DPSC_WIPER_MID;
            read_power_o     <= 1'b0;
            frame_done_o     <= 1'b0;
            frame_reject_o   <= 1'b0;
        end else begin
            wiper_register_o <= wiper_d;
            read_power_o     <= (pwr_d == DPSC_PWR_READ);
            frame_done_o     <= exec;
            frame_reject_o   <= cs_release & ~len_ok;
        end
    end

endmodule : dpsc_core

/* File: hw/dpsc_defs.svh */
`ifndef DPSC_DEFS_SVH
`define DPSC_DEFS_SVH

// ----------------------------------------------------------------------------
// Frame layout
// ----------------------------------------------------------------------------
`define DPSC_FRAME_W       24
`define DPSC_CNT_W         5
`define DPSC_FRAME_BITS    5'h18
`define DPSC_CNT_ONE       5'h01
`define DPSC_CNT_ZERO      5'h00
`define DPSC_FRAME_ZERO    24'h00_0000

// ----------------------------------------------------------------------------
// Instruction codes
// ----------------------------------------------------------------------------
`define DPSC_OP_NOP        4'h0
`define DPSC_OP_STORE_USER 4'h3
`define DPSC_OP_READ_MEM   4'h9
`define DPSC_OP_READ_WIPER 4'hA
`define DPSC_OP_WRITE_WIPER 4'hB
`define DPSC_OP_SHIFT_LEFT 4'hC

// ----------------------------------------------------------------------------
// Spare store and wiper
// ----------------------------------------------------------------------------
`define DPSC_SLOT_FIRST    4'h2
`define DPSC_SLOT_SECOND   4'h3
`define DPSC_SLOT_DEPTH    16
`define DPSC_WORD_ZERO     16'h0000
`define DPSC_WIPER_W       10
`define DPSC_WIPER_MID     10'h200
`define DPSC_WIPER_FULL    10'h3FF
`define DPSC_WIPER_PAD     6'h00

`endif

/* File: hw/dpsc_pkg.sv */
package dpsc_pkg;

`include "dpsc_defs.svh"

    // ------------------------------------------------------------------------
    // Frame fields
    // ------------------------------------------------------------------------
    typedef struct packed {
        logic [3:0]  opcode;
        logic [3:0]  addr;
        logic [15:0] data;
    } dpsc_frame_s;

    typedef logic [`DPSC_WIPER_W-1:0] dpsc_wiper_t;

    // Power state of the device
    typedef enum logic {
        DPSC_PWR_IDLE,
        DPSC_PWR_READ
    } dpsc_pwr_e;

endpackage : dpsc_pkg

/* File: hw/dpsc_link.sv */
`timescale 1ns/1ps

`include "dpsc_defs.svh"

// Link-side shifter, clocked by the serial clock of the host
module dpsc_link
    import dpsc_pkg::*;
(
    // Link clock and reset
    input  wire logic                     link_clk_i,
    input  wire logic                     rst_b_i,
    // Link pins
    input  wire logic                     cs_b_i,
    input  wire logic                     serial_data_in_i,
    output logic                          serial_data_out_o,
    // Core side, quasi-static while chip select is high
    input  wire logic [`DPSC_FRAME_W-1:0] resp_i,
    output logic [`DPSC_FRAME_W-1:0]      frame_o,
    output logic [`DPSC_CNT_W-1:0]        count_o
);

    logic                     started_q;
    logic [`DPSC_FRAME_W-1:0] out_q;
    logic [`DPSC_FRAME_W-1:0] out_d;
    logic [`DPSC_CNT_W-1:0]   count_d;

    // ------------------------------------------------------------------------
    // Next values
    // ------------------------------------------------------------------------
    // First edge of a frame reloads the reply, later edges shift it
    assign out_d   = started_q ? {out_q[`DPSC_FRAME_W-2:0], 1'b0} : resp_i;
    // Count saturates so that overlong frames never wrap to 24
    assign count_d = !started_q ? `DPSC_CNT_ONE :
                     (&count_o) ? count_o : count_o + `DPSC_CNT_ONE;

    // Frame-start flag, cleared while chip select is high
    always_ff @(posedge link_clk_i or negedge rst_b_i or posedge cs_b_i) begin
        if (!rst_b_i || cs_b_i) begin
            started_q <= 1'b0;
        end else begin
            started_q <= 1'b1;
        end
    end

    // Input shifter, MSB first, and bit counter
    always_ff @(posedge link_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            frame_o <= `DPSC_FRAME_ZERO;
            count_o <= `DPSC_CNT_ZERO;
        end else begin
            frame_o <= {frame_o[`DPSC_FRAME_W-2:0], serial_data_in_i};
            count_o <= count_d;
        end
    end

    // Output shifter; pin shows bit 23 after the first rising edge
    always_ff @(posedge link_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            out_q             <= `DPSC_FRAME_ZERO;
            serial_data_out_o <= 1'b0;
        end else begin
            out_q             <= out_d;
            serial_data_out_o <= out_d[`DPSC_FRAME_W-1];
        end
    end

endmodule : dpsc_link

/* File: testbench/dpsc_core_assertions.sv */
`timescale 1ns/1ps

`include "dpsc_defs.svh"

// Port-level checks of the serial command interpreter
module dpsc_core_checker
    import dpsc_pkg::*;
(
    // Clocks and reset
    input wire logic                     clock_i,
    input wire logic                     rst_b_i,
    input wire logic                     serial_clk_i,
    // Link pins
    input wire logic                     cs_b_i,
    input wire logic                     serial_data_in_i,
    input wire logic                     serial_data_out_o,
    // Device state
    input wire logic [`DPSC_WIPER_W-1:0] wiper_register_o,
    input wire logic                     read_power_o,
    input wire logic                     frame_done_o,
    input wire logic                     frame_reject_o
);
    // ------------------------------------------------------------------------
    // Helper logic
    // ------------------------------------------------------------------------
    logic [`DPSC_FRAME_W-1:0] cap_q;

    // Opcode, saturation and doubled value seen by the checks
    wire [3:0] op   = cap_q[23:20];
    wire       sat  = wiper_register_o[9];
    wire [9:0] dbl  = {wiper_register_o[8:0], 1'b0};

    // Copy of the frame shifted in on the link, stable once select is high
    always_ff @(posedge serial_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            cap_q <= `DPSC_FRAME_ZERO;
        end else if (!cs_b_i) begin
            cap_q <= {cap_q[22:0], serial_data_in_i};
        end
    end

    // ------------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------------
    default clocking @(posedge clock_i); endclocking
    default disable iff (!rst_b_i);

    // Execution of one given opcode
    sequence s_exec(logic [3:0] code);
        frame_done_o && op == code;
    endsequence

    a_done_cs_idle: assert property (frame_done_o |-> $past(cs_b_i, 2) && $past(cs_b_i))
        else $error("frame executed while select active");
    a_done_pulse_one: assert property (frame_done_o |=> !frame_done_o && !frame_reject_o)
        else $error("done pulse too long");
    a_reject_pulse_one: assert property (frame_reject_o |-> !frame_done_o ##1 !frame_reject_o)
        else $error("reject pulse wrong");
    a_reject_keeps_wiper: assert property (frame_reject_o |-> $stable(wiper_register_o))
        else $error("rejected frame moved wiper");
    a_wiper_write_load: assert property (s_exec(`DPSC_OP_WRITE_WIPER) |-> wiper_register_o == cap_q[9:0])
        else $error("wiper not loaded");
    a_wiper_shift_double: assert property (s_exec(`DPSC_OP_SHIFT_LEFT)
        |-> wiper_register_o == ($past(sat, 2) ? `DPSC_WIPER_FULL : $past(dbl, 2)))
        else $error("wiper not doubled");
    a_wiper_change_cause: assert property ($changed(wiper_register_o) |-> ##[0:1] frame_done_o)
        else $error("wiper changed without a frame");
    a_read_power_on: assert property (s_exec(`DPSC_OP_READ_MEM) or s_exec(`DPSC_OP_READ_WIPER)
        |-> read_power_o)
        else $error("read power not entered");
    a_nop_power_idle: assert property (s_exec(`DPSC_OP_NOP) |-> !read_power_o)
        else $error("idle power not restored");
    a_power_change_cause: assert property ($changed(read_power_o) |-> ##[0:1] frame_done_o)
        else $error("power state changed without a frame");
endmodule : dpsc_core_checker

bind dpsc_core dpsc_core_checker u_chk (
    .clock_i(clock_i), .rst_b_i(rst_b_i), .serial_clk_i(serial_clk_i), .cs_b_i(cs_b_i),
    .serial_data_in_i(serial_data_in_i), .serial_data_out_o(serial_data_out_o),
    .wiper_register_o(wiper_register_o), .read_power_o(read_power_o),
    .frame_done_o(frame_done_o), .frame_reject_o(frame_reject_o));

/* File: testbench/dpsc_host_model.sv */
`timescale 1ns/1ps

// Host controller driving frames onto the serial link
module dpsc_host_model (
    // Frame request
    input  wire logic        go_i,
    input  wire logic [23:0] frame_i,
    input  wire logic [4:0]  bits_i,
    output logic [23:0]      reply_o,
    // Link pins
    output logic             serial_clk_o,
    output logic             cs_b_o,
    output logic             serial_data_in_o,
    input  wire logic        serial_data_out_i
);
    // Idle link: clock parked, select released
    initial begin
        serial_clk_o = 1'b0;
        cs_b_o       = 1'b1;
        serial_data_in_o = 1'b0;
        reply_o      = 24'h00_0000;
    end

    // One frame, MSB first, reply taken on the falling edge
    always @(posedge go_i) begin
        #13 cs_b_o = 1'b0;
        for (int k = 0; k < bits_i; k++) begin
            serial_data_in_o = frame_i[23 - k];
            #16 serial_clk_o = 1'b1;
            #16 serial_clk_o = 1'b0;
            reply_o = {reply_o[22:0], serial_data_out_i};
        end
        #13 cs_b_o = 1'b1;
        serial_data_in_o = ~serial_data_in_o; // Released line does not keep its last value
    end
endmodule : dpsc_host_model

/* File: testbench/tb_top.sv */
`timescale 1ns/1ps

// Self-checking bench of the serial command interpreter
module tb_top;
    logic        clock_i = 1'b0;
    logic        rst_b_i = 1'b0;
    logic        go      = 1'b0;
    logic [23:0] tx      = 24'h00_0000;
    logic [4:0]  nbits   = 5'h18;
    wire         sclk, cs_b, host_din, host_dout, rpw, done, rej;
    wire  [23:0] rx;
    wire  [9:0]  wiper;
    int          errors = 0;
    int          n_compared = 0;

    always #50 clock_i = ~clock_i;

    dpsc_host_model u_host (.go_i(go), .frame_i(tx), .bits_i(nbits), .reply_o(rx),
        .serial_clk_o(sclk), .cs_b_o(cs_b), .serial_data_in_o(host_din),
        .serial_data_out_i(host_dout));

    dpsc_core dut (.clock_i(clock_i), .rst_b_i(rst_b_i), .serial_clk_i(sclk), .cs_b_i(cs_b),
        .serial_data_in_i(host_din), .serial_data_out_o(host_dout), .wiper_register_o(wiper),
        .read_power_o(rpw), .frame_done_o(done), .frame_reject_o(rej));

    // ------------------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------------------
    task automatic stop_test();
        $display("compared %0d, mismatches %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : stop_test

    task automatic chk(input logic [23:0] got, input logic [23:0] exp);
        n_compared++;
        if (got !== exp) begin
            errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    // One frame of n bits; returns reply and the done and reject pulses
    task automatic xfer(input logic [23:0] f, input logic [4:0] n,
                        output logic [23:0] r, output logic d, output logic j);
        d = 1'b0;
        j = 1'b0;
        @(posedge clock_i) begin
            tx <= f;
            nbits <= n;
            go <= 1'b1;
        end
        @(posedge clock_i) go <= 1'b0;
        for (int t = 0; t < 40 && !(d || j); t++) begin
            @(posedge clock_i);
            #1;
            d = (done === 1'b1);
            j = (rej === 1'b1);
        end
        r = rx;
        repeat (6) @(posedge clock_i);
    endtask : xfer

    // Full frame that must execute and return the expected reply
    task automatic run(input logic [23:0] f, input logic [23:0] exp);
        logic [23:0] r;
        logic        d, j;
        xfer(f, 5'h18, r, d, j);
        chk(r, exp);
        chk({23'h0, d}, 24'h00_0001);
    endtask : run

    // ------------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------------
    task automatic t_store();
        chk({14'h0, wiper}, 24'h00_0200);
        run(24'h32_AAAA, 24'h00_0000);
        run(24'h33_5555, 24'h32_AAAA);
        run(24'h3F_1234, 24'h33_5555);
        $display("store test done");
    endtask : t_store

    task automatic t_readback();
        run(24'h92_0000, 24'h3F_1234);
        chk({23'h0, rpw}, 24'h00_0001);
        run(24'h00_0000, 24'h92_AAAA);
        chk({23'h0, rpw}, 24'h00_0000);
        run(24'h93_0000, 24'h00_0000);
        run(24'h9F_0000, 24'h93_5555);
        run(24'h00_0000, 24'h9F_1234);
        $display("readback test done");
    endtask : t_readback

    task automatic t_wiper();
        run(24'hB0_0200, 24'h00_0000);
        chk({14'h0, wiper}, 24'h00_0200);
        run(24'hC0_0000, 24'hB0_0200);
        chk({14'h0, wiper}, 24'h00_03FF);
        run(24'hA0_0000, 24'hC0_0000);
        chk({23'h0, rpw}, 24'h00_0001);
        run(24'h00_0000, 24'hA0_03FF);
        run(24'hB0_0123, 24'h00_0000);
        run(24'hC0_0000, 24'hB0_0123);
        chk({14'h0, wiper}, 24'h00_0246);
        $display("wiper test done");
    endtask : t_wiper

    task automatic t_reject();
        logic [23:0] r;
        logic        d, j;
        xfer(24'hB0_0155, 5'h17, r, d, j);
        chk({22'h0, d, j}, 24'h00_0001);
        chk({14'h0, wiper}, 24'h00_0246);
        run(24'h00_0000, 24'hC0_0000);
        $display("reject test done");
    endtask : t_reject

    // ------------------------------------------------------------------------
    // Main sequence and watchdog
    // ------------------------------------------------------------------------
    initial begin
        repeat (20) @(posedge clock_i);
        rst_b_i <= 1'b1;
        repeat (3) @(posedge clock_i);
        t_store();
        t_readback();
        t_wiper();
        t_reject();
        stop_test();
    end

    initial begin
        #200_000;
        errors++;
        $display("watchdog expired");
        stop_test();
    end
endmodule : tb_top
